/* File: common/e1cd_pkg.sv */
package e1cd_pkg;
    // register offsets
    localparam logic [7:0] OFS_ACTIVATE      = 8'h16;
    localparam logic [7:0] OFS_INSERT_PAT    = 8'h17;
    localparam logic [7:0] OFS_DETECT_PAT    = 8'h18;
    localparam logic [7:0] OFS_DETECT_MASK   = 8'h19;
    localparam logic [7:0] OFS_CONTROL       = 8'h1a;
    localparam logic [7:0] OFS_IRQ_MASK0     = 8'h1b;
    localparam logic [7:0] OFS_STATUS        = 8'h20;
    localparam logic [7:0] OFS_BIT_ERR_CNT   = 8'h21;
    localparam logic [7:0] OFS_IRQ_PENDING   = 8'h22;
    localparam logic [7:0] OFS_IRQ_PENDING_X = 8'h23;
    // reset values
    localparam logic [7:0] RST_BYTE          = 8'h00;
    // activate register fields
    localparam int BIT_INSERT_ACTIVATE       = 1;
    localparam int BIT_DETECT_ARM            = 0;
    // control word fields
    localparam int BIT_SINGLE_FRAME          = 7;
    localparam int BIT_SUSPEND               = 6;
    localparam int BIT_TX_SIG_MODE           = 4;
    localparam int BIT_SIG_SOURCE            = 3;
    localparam int BIT_ERR_SOURCE            = 2;
    localparam logic [7:0] CONTROL_USED      = 8'hdc;
    localparam logic [7:0] ACTIVATE_USED     = 8'h03;
    // mask word zero fields, same positions in the pending register
    localparam int BIT_SYNC_LOSS             = 7;
    localparam int BIT_REMOTE_ALARM          = 6;
    localparam int BIT_ALL_ONES              = 5;
    localparam int BIT_SLOT16_ALL_ONES       = 4;
    localparam int BIT_SIGNAL_LOSS           = 3;
    localparam int BIT_FRAMING_ERROR         = 2;
    localparam int BIT_VIOLATION_WRAP        = 1;
    localparam int BIT_FRAME_SLIP            = 0;
    // status fields
    localparam int BIT_SLIP_OCCURRED         = 0;
    localparam int BIT_SLIP_DIRECTION        = 1;
    localparam int BIT_DETECT_MATCHED        = 2;
    localparam int BIT_DETECT_ARMED          = 3;
    // interrupt vectors
    localparam logic [7:0] VEC_NONE          = 8'h00;
    localparam logic [7:0] VEC_SYNC          = 8'h80;
    localparam logic [7:0] VEC_ALARM         = 8'h40;
    localparam logic [7:0] VEC_FRAME_ERR     = 8'h20;
    localparam logic [7:0] VEC_COUNTER_WRAP  = 8'h10;
    localparam logic [7:0] VEC_SLIP          = 8'h04;
    localparam logic [7:0] VEC_DETECT        = 8'h02;
    localparam logic [15:0] VIOLATION_MAX    = 16'hffff;

    typedef enum logic [1:0] {
        DET_IDLE  = 2'b01,
        DET_ARMED = 2'b10
    } e1cd_det_state_t;
endpackage : e1cd_pkg

/* File: verification/e1cd_line_model.sv */
`timescale 1ns/1ns
`default_nettype none
// far side of the slot streams: one-cycle slot pulses, data scrambled between slots
module e1cd_line_model (
    // clock
    input  wire logic       core_clk,
    // slot streams
    output logic            tx_valid,
    output logic [4:0]      tx_num,
    output logic [7:0]      tx_data,
    output logic            rx_valid,
    output logic [4:0]      rx_num,
    output logic [7:0]      rx_data
);
    initial begin
        {tx_valid, tx_num, tx_data, rx_valid, rx_num, rx_data} = '0;
    end
    task automatic tx(input logic [4:0] n, input logic [7:0] d);
        @(posedge core_clk) {tx_valid, tx_num, tx_data} <= {1'b1, n, d};
        @(posedge core_clk) {tx_valid, tx_data} <= {1'b0, ~d}; // no stale byte outside a slot
    endtask : tx
    task automatic rx(input logic [4:0] n, input logic [7:0] d);
        @(posedge core_clk) {rx_valid, rx_num, rx_data} <= {1'b1, n, d};
        @(posedge core_clk) {rx_valid, rx_data} <= {1'b0, ~d};
    endtask : rx
endmodule : e1cd_line_model
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import e1cd_pkg::*;
;
    logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tx_out_data, irq_vector;
    logic [31:0] ins_sel = 32'h0000_0008, det_sel = 32'h0000_0020;
    logic [3:0] sig_reg = 4'ha, sig_ser = 4'h5, tx_cas_bits;
    logic sync_loss = 0, tx_v, rx_v, irq_out, irq_oe, tx_out_valid, mode_sel, one_frame;
    logic en = 1, slip = 0, slip_dir = 0, under = 0, over = 0, fas_v = 0, bert_v = 0;
    logic [4:0] alm = 5'h00;
    logic [6:0] fas_e = 7'h00;
    logic [7:0] bert_m = 8'h00;
    logic [15:0] viol = 16'h0000;
    logic [4:0] tx_n, rx_n;
    logic [7:0] tx_d, rx_d;
    int bad_count = 0, checks_done = 0, cyc = 0;
    always #10 core_clk = ~core_clk;
    e1cd_line_model lm (.core_clk(core_clk), .tx_valid(tx_v), .tx_num(tx_n), .tx_data(tx_d),
        .rx_valid(rx_v), .rx_num(rx_n), .rx_data(rx_d));
    e1cd_ctrl DUT (.core_clk(core_clk), .rst_b(rst_b), .clk_en(en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_slot_valid(tx_v), .tx_slot_num(tx_n), .tx_slot_data(tx_d), .slot_insert_select(ins_sel),
        .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .rx_slot_valid(rx_v),
        .rx_slot_num(rx_n), .rx_slot_data(rx_d), .slot_detect_select(det_sel),
        .reg_sig_bits(sig_reg), .second_serial_control_input(sig_ser),
        .tx_signalling_mode_select(mode_sel), .tx_cas_bits(tx_cas_bits),
        .single_frame_buffer_select(one_frame), .ctrl_slip(slip), .ctrl_slip_dir(slip_dir),
        .buf_underflow(under), .buf_overflow(over), .fas_valid(fas_v), .fas_err_bits(fas_e),
        .bert_valid(bert_v), .bert_mismatch_bits(bert_m), .frame_sync_loss(sync_loss),
        .remote_alarm(alm[4]), .all_ones_alarm(alm[3]), .slot16_all_ones(alm[2]), .signal_loss(alm[1]),
        .framing_error(alm[0]), .violation_count(viol), .irq_out(irq_out), .irq_oe(irq_oe),
        .irq_vector(irq_vector));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic edges(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : edges
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            conclude;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        for (int a = 8'h17; a <= 8'h1b; a++) rd(8'(a), 8'h00);
        wr(8'h1a, 8'hff);
        rd(8'h1a, 8'hdc);
        chk({6'h0, one_frame, mode_sel}, 8'h03);
        rd(8'h30, 8'h00);
        wr(8'h1a, 8'h08);
        edges(2);
        chk({4'h0, tx_cas_bits}, 8'h0a);
        wr(8'h1a, 8'h00);
        edges(2);
        chk({4'h0, tx_cas_bits}, 8'h05);
        chk({6'h0, one_frame, mode_sel}, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_insert;
        wr(8'h17, 8'ha5);
        lm.tx(5'd3, 8'h11);
        #1 chk(tx_out_data, 8'h11);
        chk({7'h0, tx_out_valid}, 8'h01);
        wr(8'h16, 8'h02);
        #1 chk({7'h0, tx_out_valid}, 8'h00);
        lm.tx(5'd3, 8'h11);
        #1 chk(tx_out_data, 8'ha5);
        lm.tx(5'd4, 8'h22);
        #1 chk(tx_out_data, 8'h22);
        wr(8'h16, 8'h00);
        $display("test insert done");
    endtask : t_insert
    task automatic t_detect;
        wr(8'h18, 8'h3c);
        wr(8'h19, 8'hf0);
        wr(8'h16, 8'h01);
        lm.rx(5'd6, 8'h3c);
        #1 chk({7'h0, irq_out}, 8'h00);
        lm.rx(5'd5, 8'h7c);
        #1 chk({7'h0, irq_out}, 8'h00);
        lm.rx(5'd5, 8'h3f);
        #1 chk({7'h0, irq_out}, 8'h01);
        edges(1);
        chk(irq_vector, 8'h02);
        rd(8'h20, 8'h04);
        wr(8'h23, 8'h01);
        lm.rx(5'd5, 8'h3c);
        #1 chk({7'h0, irq_out}, 8'h00);
        wr(8'h16, 8'h00);
        wr(8'h16, 8'h01);
        lm.rx(5'd5, 8'h3c);
        #1 chk({7'h0, irq_out}, 8'h01);
        wr(8'h23, 8'h01);
        wr(8'h16, 8'h00);
        $display("test detect done");
    endtask : t_detect
    task automatic t_irq;
        wr(8'h1a, 8'h40);
        #1 chk({7'h0, irq_oe}, 8'h00);
        @(posedge core_clk) sync_loss <= 1'b1;
        rd(8'h22, 8'h00);
        @(posedge core_clk) sync_loss <= 1'b0;
        wr(8'h1a, 8'h00);
        wr(8'h1b, 8'h80);
        #1 chk({7'h0, irq_oe}, 8'h01);
        @(posedge core_clk) sync_loss <= 1'b1;
        edges(3);
        chk({7'h0, irq_out}, 8'h00);
        @(posedge core_clk) sync_loss <= 1'b0;
        wr(8'h1b, 8'h00);
        @(posedge core_clk) sync_loss <= 1'b1;
        edges(3);
        chk({7'h0, irq_out}, 8'h01);
        chk(irq_vector, 8'h80);
        wr(8'h22, 8'h80);
        #1 chk({7'h0, irq_out}, 8'h00);
        @(posedge core_clk) sync_loss <= 1'b0;
        $display("test irq done");
    endtask : t_irq
    task automatic t_events;
        @(posedge core_clk) alm <= 5'h1e;
        edges(3);
        chk(irq_vector, 8'h40);
        rd(8'h22, 8'h78);
        wr(8'h22, 8'hff);
        @(posedge core_clk) alm <= 5'h1f;
        edges(3);
        chk(irq_vector, 8'h20);
        wr(8'h22, 8'hff);
        wr(8'h1b, 8'h04);
        @(posedge core_clk) alm <= 5'h00;
        @(posedge core_clk) alm <= 5'h01;
        edges(2);
        rd(8'h22, 8'h00);
        wr(8'h1b, 8'h00);
        @(posedge core_clk) viol <= 16'hffff;
        @(posedge core_clk) viol <= 16'h0000;
        edges(2);
        chk(irq_vector, 8'h10);
        wr(8'h22, 8'hff);
        $display("test events done");
    endtask : t_events
    task automatic slips(input logic [3:0] v);
        @(posedge core_clk) {slip, slip_dir, under, over} <= v;
        @(posedge core_clk) {slip, slip_dir, under, over} <= 4'h0;
    endtask : slips
    task automatic t_slips;
        slips(4'hc);
        edges(1);
        chk(irq_vector, 8'h04);
        rd(8'h20, 8'h07);
        wr(8'h22, 8'hff);
        wr(8'h1a, 8'h80);
        slips(4'h8);
        rd(8'h20, 8'h06);
        rd(8'h22, 8'h00);
        slips(4'h2);
        rd(8'h20, 8'h05);
        slips(4'h1);
        rd(8'h20, 8'h07);
        wr(8'h1a, 8'h00);
        $display("test slips done");
    endtask : t_slips
    task automatic t_counts;
        @(posedge core_clk) {fas_v, fas_e} <= {1'b1, 7'h45};
        @(posedge core_clk) fas_v <= 1'b0;
        rd(8'h21, 8'h03);
        wr(8'h1a, 8'h04);
        @(posedge core_clk) {bert_v, bert_m, fas_v} <= {1'b1, 8'hf0, 1'b1};
        @(posedge core_clk) {bert_v, fas_v} <= 2'b00;
        rd(8'h21, 8'h07);
        wr(8'h1a, 8'h00);
        @(posedge core_clk) en <= 1'b0;
        wr(8'h17, 8'h5a);
        @(posedge core_clk) en <= 1'b1;
        rd(8'h17, 8'ha5);
        $display("test counts done");
    endtask : t_counts
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        t_regs;
        t_insert;
        t_detect;
        t_irq;
        t_events;
        t_slips;
        t_counts;
        conclude;
    end
endmodule : tb_top
`default_nettype wire

/* File: verilog/e1cd_ctrl.sv */
// Behaviour
// - insert byte, msb first, reset zero
// - per-slot insert select picks any slots
// - detect byte compared in selected rx slots
// - compare mask one includes, zero excludes
// - bit7 set: one frame, no slip, flow flags
// - bit7 clear: two frames, controlled slips
// - bit6 set: irq high-z, sources ignored
// - bit4 picks CAS or CCS transmit
// - bit3 picks register or stream signalling
// - bit2 clear: count FAS bit errors
// - bit2 set: count compare buffer mismatches
// - mask zero enables, one masks, reset zero
// - sync loss gives vector 10000000
// - alarms and signal loss give 01000000
// - FAS error gives vector 00100000
// - violation counter wrap gives 00010000
// - controlled slip gives vector 00000100
// - insertion only while insert activate set
// - detect armed by rising arm, stops after match
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module e1cd_ctrl
    import e1cd_pkg::*;
#(
    parameter int SLOTS   = 32,
    parameter int ERR_W   = 8
) (
    // clock, reset, enable
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // transmit slot stream
    input  wire logic              tx_slot_valid,
    input  wire logic [4:0]        tx_slot_num,
    input  wire logic [7:0]        tx_slot_data,
    input  wire logic [SLOTS-1:0]  slot_insert_select,
    output logic                   tx_out_valid,
    output logic      [7:0]        tx_out_data,
    // receive slot stream
    input  wire logic              rx_slot_valid,
    input  wire logic [4:0]        rx_slot_num,
    input  wire logic [7:0]        rx_slot_data,
    input  wire logic [SLOTS-1:0]  slot_detect_select,
    // signalling
    input  wire logic [3:0]        reg_sig_bits,
    input  wire logic [3:0]        second_serial_control_input,
    output logic                   tx_signalling_mode_select,
    output logic      [3:0]        tx_cas_bits,
    // elastic buffer
    output logic                   single_frame_buffer_select,
    input  wire logic              ctrl_slip,
    input  wire logic              ctrl_slip_dir,
    input  wire logic              buf_underflow,
    input  wire logic              buf_overflow,
    // bit error sources
    input  wire logic              fas_valid,
    input  wire logic [6:0]        fas_err_bits,
    input  wire logic              bert_valid,
    input  wire logic [7:0]        bert_mismatch_bits,
    // alarm and counter conditions
    input  wire logic              frame_sync_loss,
    input  wire logic              remote_alarm,
    input  wire logic              all_ones_alarm,
    input  wire logic              slot16_all_ones,
    input  wire logic              signal_loss,
    input  wire logic              framing_error,
    input  wire logic [15:0]       violation_count,
    // interrupt pin
    output logic                   irq_out,
    output logic                   irq_oe,
    output logic      [7:0]        irq_vector
);
    // slot numbers are 5 bits wide and the counter readback holds at most 8 bits
    if (SLOTS != 32 || ERR_W < 4 || ERR_W > 8) begin : g_bad_params
        $error("e1cd_ctrl: unsupported SLOTS or ERR_W");
    end

    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'b000, v[i]};
        end
        return n;
    endfunction : ones8

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]          activate_q,  activate_d;
    logic [7:0]          insert_q,    insert_d;
    logic [7:0]          detpat_q,    detpat_d;
    logic [7:0]          detmask_q,   detmask_d;
    logic [7:0]          control_q,   control_d;
    logic [7:0]          mask0_q,     mask0_d;
    logic [7:0]          pend_q,      pend_d;
    logic                pend_det_q,  pend_det_d;
    logic [7:0]          cond_q,      cond_d;
    logic [15:0]         viol_q,      viol_d;
    logic [ERR_W-1:0]    err_cnt_q,   err_cnt_d;
    logic                slip_occ_q,  slip_occ_d;
    logic                slip_dir_q,  slip_dir_d;
    logic                matched_q,   matched_d;
    e1cd_det_state_t     det_q,       det_d;
    logic [7:0]          rdata_q,     rdata_d;
    logic                txv_q,       txv_d;
    logic [7:0]          txd_q,       txd_d;
    logic [3:0]          cas_q,       cas_d;
    logic [7:0]          vec_q,       vec_d;

    logic [7:0]          cond_now;
    logic [7:0]          events;
    logic                match;
    logic                suspend;
    logic                wr_pend;
    logic                wr_pend_x;
    logic [ERR_W-1:0]    err_inc;

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        suspend   = control_q[BIT_SUSPEND];
        wr_pend   = 1'b0;
        wr_pend_x = 1'b0;
        activate_d = activate_q;
        insert_d   = insert_q;
        detpat_d   = detpat_q;
        detmask_d  = detmask_q;
        control_d  = control_q;
        mask0_d    = mask0_q;
        rdata_d    = RST_BYTE;
        // register writes
        if (reg_wr) begin
            if (reg_addr == OFS_ACTIVATE) begin
                activate_d = reg_wdata & ACTIVATE_USED;
            end else if (reg_addr == OFS_INSERT_PAT) begin
                insert_d = reg_wdata;
            end else if (reg_addr == OFS_DETECT_PAT) begin
                detpat_d = reg_wdata;
            end else if (reg_addr == OFS_DETECT_MASK) begin
                detmask_d = reg_wdata;
            end else if (reg_addr == OFS_CONTROL) begin
                control_d = reg_wdata & CONTROL_USED;
            end else if (reg_addr == OFS_IRQ_MASK0) begin
                mask0_d = reg_wdata;
            end else if (reg_addr == OFS_IRQ_PENDING) begin
                wr_pend = 1'b1;
            end else if (reg_addr == OFS_IRQ_PENDING_X) begin
                wr_pend_x = 1'b1;
            end
        end
        // register reads, answered next cycle; unmapped reads zero
        if (reg_rd) begin
            if (reg_addr == OFS_ACTIVATE) begin
                rdata_d = activate_q;
            end else if (reg_addr == OFS_INSERT_PAT) begin
                rdata_d = insert_q;
            end else if (reg_addr == OFS_DETECT_PAT) begin
                rdata_d = detpat_q;
            end else if (reg_addr == OFS_DETECT_MASK) begin
                rdata_d = detmask_q;
            end else if (reg_addr == OFS_CONTROL) begin
                rdata_d = control_q;
            end else if (reg_addr == OFS_IRQ_MASK0) begin
                rdata_d = mask0_q;
            end else if (reg_addr == OFS_STATUS) begin
                rdata_d = {4'h0, det_q == DET_ARMED, matched_q, slip_dir_q, slip_occ_q};
            end else if (reg_addr == OFS_BIT_ERR_CNT) begin
                rdata_d = 8'(err_cnt_q);
            end else if (reg_addr == OFS_IRQ_PENDING) begin
                rdata_d = pend_q;
            end else if (reg_addr == OFS_IRQ_PENDING_X) begin
                rdata_d = {7'h00, pend_det_q};
            end
        end

        // transmit path: pattern replaces data in selected slots
        txv_d = tx_slot_valid;
        txd_d = txd_q;
        if (tx_slot_valid) begin
            if (activate_q[BIT_INSERT_ACTIVATE] && slot_insert_select[tx_slot_num]) begin
                txd_d = insert_q;
            end else begin
                txd_d = tx_slot_data;
            end
        end
        // signalling source
        cas_d = control_q[BIT_SIG_SOURCE] ? reg_sig_bits : second_serial_control_input;

        // detect: masked compare in selected slots while armed
        match = (det_q == DET_ARMED) && rx_slot_valid && slot_detect_select[rx_slot_num]
                && (((rx_slot_data ^ detpat_q) & detmask_q) == 8'h00);
        det_d     = det_q;
        matched_d = matched_q;
        case (det_q)
            DET_IDLE: begin
                // only a fresh zero-to-one write arms the search
                if (activate_d[BIT_DETECT_ARM] && !activate_q[BIT_DETECT_ARM]) begin
                    det_d     = DET_ARMED;
                    matched_d = 1'b0;
                end
            end
            DET_ARMED: begin
                if (match || !activate_q[BIT_DETECT_ARM]) begin
                    det_d = DET_IDLE;
                end
                if (match) begin
                    matched_d = 1'b1;
                end
            end
            default: begin
                det_d = DET_IDLE;
            end
        endcase

        // slips: controlled slips only with the two-frame buffer
        slip_occ_d = slip_occ_q;
        slip_dir_d = slip_dir_q;
        if (reg_rd && reg_addr == OFS_STATUS) begin
            slip_occ_d = 1'b0;
        end
        if (control_q[BIT_SINGLE_FRAME]) begin
            if (buf_underflow || buf_overflow) begin
                slip_occ_d = 1'b1;
                slip_dir_d = buf_overflow;
            end
        end else if (ctrl_slip) begin
            slip_occ_d = 1'b1;
            slip_dir_d = ctrl_slip_dir;
        end

        // bit error counter source
        err_inc = '0;
        if (control_q[BIT_ERR_SOURCE]) begin
            if (bert_valid) begin
                err_inc = ERR_W'(ones8(bert_mismatch_bits));
            end
        end else if (fas_valid) begin
            err_inc = ERR_W'(ones8({1'b0, fas_err_bits}));
        end
        err_cnt_d = err_cnt_q + err_inc;

        // interrupt events: rising conditions and single pulses
        cond_now = {frame_sync_loss, remote_alarm, all_ones_alarm, slot16_all_ones,
                    signal_loss, framing_error, 1'b0, 1'b0};
        cond_d   = cond_now;
        viol_d   = violation_count;
        events   = cond_now & ~cond_q;
        events[BIT_VIOLATION_WRAP] = (viol_q == VIOLATION_MAX) && (violation_count == 16'h0000);
        events[BIT_FRAME_SLIP]     = ctrl_slip && !control_q[BIT_SINGLE_FRAME];
        // software clears with ones, a new event in the same cycle wins
        pend_d = pend_q;
        if (wr_pend) begin
            pend_d = pend_q & ~reg_wdata;
        end
        pend_det_d = pend_det_q;
        if (wr_pend_x && reg_wdata[0]) begin
            pend_det_d = 1'b0;
        end
        if (!suspend) begin
            pend_d     = pend_d | (events & ~mask0_q);
            pend_det_d = pend_det_d | match;
        end

        // vector of the highest pending source
        if (pend_q[BIT_SYNC_LOSS]) begin
            vec_d = VEC_SYNC;
        end else if (|pend_q[BIT_REMOTE_ALARM:BIT_SIGNAL_LOSS]) begin
            vec_d = VEC_ALARM;
        end else if (pend_q[BIT_FRAMING_ERROR]) begin
            vec_d = VEC_FRAME_ERR;
        end else if (pend_q[BIT_VIOLATION_WRAP]) begin
            vec_d = VEC_COUNTER_WRAP;
        end else if (pend_q[BIT_FRAME_SLIP]) begin
            vec_d = VEC_SLIP;
        end else if (pend_det_q) begin
            vec_d = VEC_DETECT;
        end else begin
            vec_d = VEC_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            activate_q <= RST_BYTE;
            insert_q   <= RST_BYTE;
            detpat_q   <= RST_BYTE;
            detmask_q  <= RST_BYTE;
            control_q  <= RST_BYTE;
            mask0_q    <= RST_BYTE;
            pend_q     <= RST_BYTE;
            pend_det_q <= 1'b0;
            cond_q     <= RST_BYTE;
            viol_q     <= 16'h0000;
            err_cnt_q  <= '0;
            slip_occ_q <= 1'b0;
            slip_dir_q <= 1'b0;
            matched_q  <= 1'b0;
            det_q      <= DET_IDLE;
            rdata_q    <= RST_BYTE;
            txv_q      <= 1'b0;
            txd_q      <= RST_BYTE;
            cas_q      <= 4'h0;
            vec_q      <= VEC_NONE;
        end else if (clk_en) begin
            activate_q <= activate_d;
            insert_q   <= insert_d;
            detpat_q   <= detpat_d;
            detmask_q  <= detmask_d;
            control_q  <= control_d;
            mask0_q    <= mask0_d;
            pend_q     <= pend_d;
            pend_det_q <= pend_det_d;
            cond_q     <= cond_d;
            viol_q     <= viol_d;
            err_cnt_q  <= err_cnt_d;
            slip_occ_q <= slip_occ_d;
            slip_dir_q <= slip_dir_d;
            matched_q  <= matched_d;
            det_q      <= det_d;
            rdata_q    <= rdata_d;
            txv_q      <= txv_d;
            txd_q      <= txd_d;
            cas_q      <= cas_d;
            vec_q      <= vec_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata                  = rdata_q;
    assign tx_out_valid               = txv_q;
    assign tx_out_data                = txd_q;
    assign tx_cas_bits                = cas_q;
    assign tx_signalling_mode_select  = control_q[BIT_TX_SIG_MODE];
    assign single_frame_buffer_select = control_q[BIT_SINGLE_FRAME];
    assign irq_out    = !suspend && (pend_q != 8'h00 || pend_det_q);
    assign irq_oe     = !suspend;
    assign irq_vector = vec_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_arm_write;
        clk_en && reg_wr && reg_addr == OFS_ACTIVATE && reg_wdata[BIT_DETECT_ARM]
            && !activate_q[BIT_DETECT_ARM] && det_q == DET_IDLE;
    endsequence
    sequence s_armed_then_match;
        clk_en && match;
    endsequence

    a_insert_slot: assert property (clk_en && tx_slot_valid && activate_q[BIT_INSERT_ACTIVATE]
        && slot_insert_select[tx_slot_num] |=> tx_out_data == $past(insert_q))
        else $error("insert pattern not sent");
    a_insert_off: assert property (clk_en && tx_slot_valid && !activate_q[BIT_INSERT_ACTIVATE]
        |=> tx_out_data == $past(tx_slot_data))
        else $error("data replaced while insertion off");
    a_detect_arms: assert property (s_arm_write |=> det_q == DET_ARMED)
        else $error("rising arm bit did not arm detect");
    a_detect_stops: assert property (s_armed_then_match |=> det_q == DET_IDLE && matched_q)
        else $error("detect kept running after a match");
    a_match_masked: assert property (clk_en && det_q == DET_ARMED && rx_slot_valid
        && slot_detect_select[rx_slot_num] && detmask_q == 8'h00 && activate_q[BIT_DETECT_ARM]
        |=> matched_q)
        else $error("all-excluded mask did not match");
    a_irq_suspend: assert property (control_q[BIT_SUSPEND] |-> !irq_oe && !irq_out)
        else $error("irq driven while suspended");
    a_sync_vector: assert property (clk_en && pend_q[BIT_SYNC_LOSS] |=> irq_vector == VEC_SYNC)
        else $error("sync loss vector wrong");
    a_mask_blocks: assert property (clk_en && mask0_q[BIT_FRAMING_ERROR] && !pend_q[BIT_FRAMING_ERROR]
        && !wr_pend ##0 !$changed(mask0_q) |=> !pend_q[BIT_FRAMING_ERROR] || $past(!mask0_q[BIT_FRAMING_ERROR]))
        else $error("masked source became pending");
    a_slip_single: assert property (clk_en && control_q[BIT_SINGLE_FRAME] && ctrl_slip
        && !buf_underflow && !buf_overflow |=> !pend_q[BIT_FRAME_SLIP] || $past(pend_q[BIT_FRAME_SLIP]))
        else $error("controlled slip flagged with single frame buffer");
    a_wrap_irq: assert property (clk_en && !control_q[BIT_SUSPEND] && !mask0_q[BIT_VIOLATION_WRAP]
        && viol_q == VIOLATION_MAX && violation_count == 16'h0000 |=> pend_q[BIT_VIOLATION_WRAP])
        else $error("counter wrap not pending");
    a_err_fas: assert property (clk_en && !control_q[BIT_ERR_SOURCE] && fas_valid && !reg_wr
        |=> err_cnt_q == $past(err_cnt_q) + ERR_W'(ones8({1'b0, $past(fas_err_bits)})))
        else $error("fas bit errors not counted");
endmodule : e1cd_ctrl
`default_nettype wire
